/* File: logic/edmb_pkg.sv */
/*
 * shared constants and state type for the external data memory bus
 * with dual data pointer and auxiliary bus control register.
 * assumes one oscillator clock; cpu clock periods are counted as ticks.
 */
package edmb_pkg;
	// special function register addresses
	localparam logic [7:0] SFR_PTR_HIGH   = 8'h83;
	localparam logic [7:0] SFR_PTR_LOW    = 8'h84;
	localparam logic [7:0] SFR_AUX_BUS    = 8'h8E;
	localparam logic [7:0] SFR_HIGH_PORT  = 8'hA0;
	localparam logic [7:0] SFR_AUX_PTR    = 8'hA2;

	// reset values and write masks
	localparam logic [7:0] AUX_BUS_RESET   = 8'h0C;
	localparam logic [7:0] AUX_PTR_RESET   = 8'h00;
	localparam logic [7:0] HIGH_PORT_RESET = 8'hFF;
	localparam logic [7:0] AUX_BUS_MASK    = 8'h2F;
	localparam logic [7:0] AUX_PTR_MASK    = 8'h09;

	// field positions
	localparam int BIT_STRETCH   = 5;
	localparam int BIT_XRS_LO    = 2;
	localparam int BIT_EXT_SEL   = 1;
	localparam int BIT_LATCH_DIS = 0;
	localparam int BIT_GF3       = 3;
	localparam int BIT_PTR_ZERO  = 2;
	localparam int BIT_PTR_SEL   = 0;

	// timing in cpu clock and oscillator periods
	localparam int CPU_PER_CYCLE      = 6;
	localparam int STROBE_CPU         = 3;
	localparam int STROBE_STRETCH_CPU = 15;
	localparam int ALE_PERIOD_CPU     = 3;
	localparam int OSC_PER_CPU_STD    = 2;
	localparam int OSC_PER_CPU_X2     = 1;
	localparam int STROBE_OSC_STD     = STROBE_CPU * OSC_PER_CPU_STD;
	localparam int STROBE_OSC_STRETCH = STROBE_STRETCH_CPU * OSC_PER_CPU_STD;

	// internal extended ram
	localparam int INTERNAL_EXTENDED_RAM_ADDR_W = 10;
	localparam int INTERNAL_EXTENDED_RAM_DEPTH  = 1024;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_WAIT   = 3'b001,
		ST_ADDR   = 3'b010,
		ST_LATCH  = 3'b011,
		ST_STROBE = 3'b100,
		ST_HOLD   = 3'b101,
		ST_XINT   = 3'b110
	} edmb_state_type;
endpackage : edmb_pkg

/* File: logic/edmb_tick.sv */
/*
 * cpu clock tick and free-running latch strobe phase.
 * assumes the oscillator is ref_clk; the speed mode comes from same-domain logic.
 */
module edmb_tick (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// mode
	input  wire logic doubleSpeed,
	// timing
	output logic      cpuTick,
	output logic      alePhase
);
	logic       divQ;
	logic [1:0] aleCntQ;

	// standard mode: one cpu clock per two oscillator periods
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			divQ <= 1'b0;
		end else begin
			divQ <= ~divQ;
		end
	end

	assign cpuTick = doubleSpeed ? 1'b1 : divQ;

	// one cpu clock high out of three gives 1/6 or 1/3 of the oscillator
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aleCntQ <= 2'h0;
		end else if (cpuTick) begin
			if (aleCntQ == 2'(edmb_pkg::ALE_PERIOD_CPU - 1)) begin
				aleCntQ <= 2'h0;
			end else begin
				aleCntQ <= aleCntQ + 2'h1;
			end
		end
	end

	assign alePhase = (aleCntQ == 2'h0);
endmodule : edmb_tick

/* File: logic/edmb_internal_extended_ram.sv */
/*
 * internal extended ram, 1024 bytes, registered read.
 * assumes the caller keeps addresses inside the configured size.
 */
module edmb_internal_extended_ram (
	// clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               rst_n,
	// access
	input  wire logic                               wrEn,
	input  wire logic                               rdEn,
	input  wire logic [edmb_pkg::INTERNAL_EXTENDED_RAM_ADDR_W-1:0]   addr,
	input  wire logic [7:0]                         wrData,
	output logic      [7:0]                         rdData
);
	logic [7:0] mem [edmb_pkg::INTERNAL_EXTENDED_RAM_DEPTH];

	// contents are volatile, so no reset on the array
	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem[addr] <= wrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdData <= 8'h00;
		end else if (rdEn) begin
			rdData <= mem[addr];
		end
	end
endmodule : edmb_internal_extended_ram

/* File: logic/edmb_bus.sv */
/*
 * external data memory bus controller with dual data pointer,
 * auxiliary bus control and pointer control registers, and internal internal_extended_ram.
 * assumes a cpu core drives the sfr port and the movx request port on ref_clk;
 * the pin-level wire is resolved outside from the output enable.
 */
// Contract
// - drive low address and high address ports
// - data shares low port with low address
// - latch strobe marks valid low address
// - active-low read strobe output
// - active-low write strobe output
// - bus cycle lasts six cpu clocks
// - stretch widens strobes three to fifteen
// - stretch gives 6 or 30 periods
// - register-indirect cycle drives high port latch
// - two pointers behind same byte addresses
// - select bit picks pointer for accesses
// - increment of select register toggles bit
// - size field sets internal ram size
// - select bit chooses internal or external
// - latch strobe free-runs when not disabled
// - bus control resets 0x0C, reserved masked
// - internal ram answers 0000h to 03FFh
// - pointer register bit 2 reads zero
// - select bit zero, set picks second
module edmb_bus (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// mode
	input  wire logic        doubleSpeedMode,
	// sfr access
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWrEn,
	input  wire logic [7:0]  sfrWrData,
	input  wire logic        sfrRdEn,
	output logic      [7:0]  sfrRdData,
	// data pointer increment
	input  wire logic        ptrInc,
	// movx request
	input  wire logic        movxReq,
	input  wire logic        movxWrite,
	input  wire logic        movxUsePtr,
	input  wire logic [7:0]  movxRegAddr,
	input  wire logic [7:0]  movxWrData,
	output logic             movxDone,
	output logic      [7:0]  movxRdData,
	// external bus pins
	input  wire logic [7:0]  lowAddrDataIn,
	output logic      [7:0]  lowAddrDataOut,
	output logic             lowAddrDataOe,
	output logic      [7:0]  highAddrPort,
	output logic             addrLatch,
	output logic             rdStrobe_n,
	output logic             wrStrobe_n
);
	edmb_pkg::edmb_state_type stateQ, stateD;
	logic [7:0]  auxBusQ;
	logic [7:0]  auxPtrQ;
	logic [7:0]  highPortQ;
	logic [15:0] ptrQ [2];
	logic [15:0] addrQ;
	logic [7:0]  wrDataQ;
	logic        writeQ;
	logic        usePtrQ;
	logic [3:0]  cntQ, cntD;
	logic [7:0]  syncAQ, syncBQ;
	logic        cpuTick, alePhase;
	logic [7:0]  xramRdData;
	logic [15:0] reqAddr;
	logic        reqInternal, take, ptrSel, stretch, latchDis, extSel;
	logic [3:0]  strobeLast;

	assign ptrSel   = auxPtrQ[edmb_pkg::BIT_PTR_SEL];
	assign stretch  = auxBusQ[edmb_pkg::BIT_STRETCH];
	assign latchDis = auxBusQ[edmb_pkg::BIT_LATCH_DIS];
	assign extSel   = auxBusQ[edmb_pkg::BIT_EXT_SEL];

	edmb_tick u_tick (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.doubleSpeed (doubleSpeedMode),
		.cpuTick     (cpuTick),
		.alePhase    (alePhase)
	);

	// register-indirect takes the high byte from the port latch
	// the pointer select bit chooses which pointer addresses
	assign reqAddr = movxUsePtr ? ptrQ[ptrSel] : {highPortQ, movxRegAddr};

	// internal ram covers (size field + 1) pages of 256 bytes
	assign reqInternal = !extSel && (reqAddr[15:10] == 6'h00)
		&& (reqAddr[9:8] <= auxBusQ[edmb_pkg::BIT_XRS_LO +: 2]);
	assign take = movxReq && (stateQ == edmb_pkg::ST_IDLE);

	// strobe length in cpu clocks, 3 or 15
	assign strobeLast = stretch ? 4'(edmb_pkg::STROBE_STRETCH_CPU - 1)
		: 4'(edmb_pkg::STROBE_CPU - 1);

	edmb_internal_extended_ram u_internal_extended_ram (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wrEn    (take && reqInternal && movxWrite),
		.rdEn    (take && reqInternal && !movxWrite),
		.addr    (reqAddr[edmb_pkg::INTERNAL_EXTENDED_RAM_ADDR_W-1:0]),
		.wrData  (movxWrData),
		.rdData  (xramRdData)
	);

	// pin input passes two flip-flops before use
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			syncAQ <= 8'h00;
			syncBQ <= 8'h00;
		end else begin
			syncAQ <= lowAddrDataIn;
			syncBQ <= syncAQ;
		end
	end

	// bus control register; reserved bits are never stored
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			auxBusQ <= edmb_pkg::AUX_BUS_RESET;
		end else if (sfrWrEn && sfrAddr == edmb_pkg::SFR_AUX_BUS) begin
			auxBusQ <= sfrWrData & edmb_pkg::AUX_BUS_MASK;
		end
	end

	// bit 2 stores nothing and reads zero, so an increment only flips
	// the select bit and leaves the general flag alone
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			auxPtrQ <= edmb_pkg::AUX_PTR_RESET;
		end else if (sfrWrEn && sfrAddr == edmb_pkg::SFR_AUX_PTR) begin
			auxPtrQ <= sfrWrData & edmb_pkg::AUX_PTR_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			highPortQ <= edmb_pkg::HIGH_PORT_RESET;
		end else if (sfrWrEn && sfrAddr == edmb_pkg::SFR_HIGH_PORT) begin
			highPortQ <= sfrWrData;
		end
	end

	// both pointers sit behind the same two addresses
	generate
		for (genvar i = 0; i < 2; i++) begin : g_ptr
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					ptrQ[i] <= 16'h0000;
				end else if (ptrSel == 1'(i)) begin
					if (sfrWrEn && sfrAddr == edmb_pkg::SFR_PTR_HIGH) begin
						ptrQ[i][15:8] <= sfrWrData;
					end else if (sfrWrEn && sfrAddr == edmb_pkg::SFR_PTR_LOW) begin
						ptrQ[i][7:0] <= sfrWrData;
					end else if (ptrInc) begin
						ptrQ[i] <= ptrQ[i] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// sfr read; unmapped addresses read zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sfrRdData <= 8'h00;
		end else if (sfrRdEn) begin
			case (sfrAddr)
				edmb_pkg::SFR_PTR_HIGH:  sfrRdData <= ptrQ[ptrSel][15:8];
				edmb_pkg::SFR_PTR_LOW:   sfrRdData <= ptrQ[ptrSel][7:0];
				edmb_pkg::SFR_AUX_BUS:   sfrRdData <= auxBusQ;
				edmb_pkg::SFR_AUX_PTR:   sfrRdData <= auxPtrQ;
				edmb_pkg::SFR_HIGH_PORT: sfrRdData <= highPortQ;
				default:                 sfrRdData <= 8'h00;
			endcase
		end
	end

	// request capture
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			addrQ   <= 16'h0000;
			wrDataQ <= 8'h00;
			writeQ  <= 1'b0;
			usePtrQ <= 1'b0;
		end else if (take) begin
			addrQ   <= reqAddr;
			wrDataQ <= movxWrData;
			writeQ  <= movxWrite;
			usePtrQ <= movxUsePtr;
		end
	end

	// cycle sequencer, advancing once per cpu clock:
	// addr 1 + latch 1 + strobe 3 + hold 1 = 6 cpu clocks
	always_comb begin
		stateD = stateQ;
		cntD   = cntQ;
		case (stateQ)
			edmb_pkg::ST_IDLE: begin
				if (take) begin
					stateD = reqInternal ? edmb_pkg::ST_XINT : edmb_pkg::ST_WAIT;
				end
			end
			edmb_pkg::ST_WAIT: begin
				if (cpuTick) begin
					stateD = edmb_pkg::ST_ADDR;
				end
			end
			edmb_pkg::ST_ADDR: begin
				if (cpuTick) begin
					stateD = edmb_pkg::ST_LATCH;
				end
			end
			edmb_pkg::ST_LATCH: begin
				if (cpuTick) begin
					stateD = edmb_pkg::ST_STROBE;
					cntD   = 4'h0;
				end
			end
			edmb_pkg::ST_STROBE: begin
				if (cpuTick) begin
					if (cntQ == strobeLast) begin
						stateD = edmb_pkg::ST_HOLD;
					end else begin
						cntD = cntQ + 4'h1;
					end
				end
			end
			edmb_pkg::ST_HOLD: begin
				if (cpuTick) begin
					stateD = edmb_pkg::ST_IDLE;
				end
			end
			edmb_pkg::ST_XINT: stateD = edmb_pkg::ST_IDLE;
			default:           stateD = edmb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stateQ <= edmb_pkg::ST_IDLE;
			cntQ   <= 4'h0;
		end else begin
			stateQ <= stateD;
			cntQ   <= cntD;
		end
	end

	// pins are registered from the next state so they change together
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lowAddrDataOut <= 8'h00;
			lowAddrDataOe  <= 1'b0;
			highAddrPort   <= edmb_pkg::HIGH_PORT_RESET;
			addrLatch      <= 1'b0;
			rdStrobe_n     <= 1'b1;
			wrStrobe_n     <= 1'b1;
		end else begin
			// address first, then write data, on the same port
			lowAddrDataOe <= (stateD == edmb_pkg::ST_ADDR) || (stateD == edmb_pkg::ST_LATCH)
				|| (writeQ && (stateD == edmb_pkg::ST_STROBE || stateD == edmb_pkg::ST_HOLD));
			lowAddrDataOut <= (stateD == edmb_pkg::ST_ADDR || stateD == edmb_pkg::ST_LATCH)
				? addrQ[7:0] : wrDataQ;
			// high byte from pointer or port latch during a cycle
			case (stateD)
				edmb_pkg::ST_ADDR, edmb_pkg::ST_LATCH,
				edmb_pkg::ST_STROBE, edmb_pkg::ST_HOLD: highAddrPort <= addrQ[15:8];
				default:                                highAddrPort <= highPortQ;
			endcase
			// the bus cycle owns the strobe; outside it, free-run unless disabled
			if (stateD == edmb_pkg::ST_ADDR) begin
				addrLatch <= 1'b1;
			end else if (stateD == edmb_pkg::ST_IDLE || stateD == edmb_pkg::ST_XINT) begin
				addrLatch <= !latchDis && alePhase;
			end else begin
				addrLatch <= 1'b0;
			end
			rdStrobe_n <= !(stateD == edmb_pkg::ST_STROBE && !writeQ);
			wrStrobe_n <= !(stateD == edmb_pkg::ST_STROBE && writeQ);
		end
	end

	// answer to the core; read data sampled on the last strobe cpu clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			movxDone   <= 1'b0;
			movxRdData <= 8'h00;
		end else begin
			movxDone <= (stateQ == edmb_pkg::ST_XINT)
				|| (stateQ == edmb_pkg::ST_HOLD && cpuTick);
			if (stateQ == edmb_pkg::ST_XINT && !writeQ) begin
				movxRdData <= xramRdData;
			end else if (stateQ == edmb_pkg::ST_STROBE && cpuTick && cntQ == strobeLast
				&& !writeQ) begin
				movxRdData <= syncBQ;
			end
		end
	end

	// helper counters for the checks below
	logic [7:0] strobeLenQ, cycLenQ;
	logic [7:0] oscPerCpu;
	assign oscPerCpu = doubleSpeedMode ? 8'(edmb_pkg::OSC_PER_CPU_X2)
		: 8'(edmb_pkg::OSC_PER_CPU_STD);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			strobeLenQ <= 8'h00;
			cycLenQ    <= 8'h00;
		end else begin
			strobeLenQ <= (!rdStrobe_n || !wrStrobe_n) ? strobeLenQ + 8'h01 : 8'h00;
			cycLenQ    <= (stateQ == edmb_pkg::ST_IDLE || stateQ == edmb_pkg::ST_WAIT
				|| stateQ == edmb_pkg::ST_XINT) ? 8'h00 : cycLenQ + 8'h01;
		end
	end

	property p_low_addr;
		@(posedge ref_clk) disable iff (!rst_n)
		(stateQ == edmb_pkg::ST_LATCH) |-> (lowAddrDataOe && lowAddrDataOut == addrQ[7:0]
			&& highAddrPort == addrQ[15:8]);
	endproperty
	a_low_addr: assert property (p_low_addr) else $error("address not on bus ports");

	property p_latch_valid;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(addrLatch) && (stateQ == edmb_pkg::ST_ADDR) |-> lowAddrDataOe ##1 lowAddrDataOe;
	endproperty
	a_latch_valid: assert property (p_latch_valid) else $error("latch strobe without address");

	property p_one_strobe;
		@(posedge ref_clk) disable iff (!rst_n)
		!(!rdStrobe_n && !wrStrobe_n) && (rdStrobe_n || !writeQ);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("read and write strobe clash");

	property p_write_data;
		@(posedge ref_clk) disable iff (!rst_n)
		!wrStrobe_n |-> (lowAddrDataOe && lowAddrDataOut == wrDataQ);
	endproperty
	a_write_data: assert property (p_write_data) else $error("write data not driven");

	property p_strobe_width;
		@(posedge ref_clk) disable iff (!rst_n)
		($rose(rdStrobe_n) || $rose(wrStrobe_n)) |-> strobeLenQ == (stretch
			? 8'(edmb_pkg::STROBE_STRETCH_CPU) : 8'(edmb_pkg::STROBE_CPU)) * oscPerCpu;
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

	property p_cycle_len;
		@(posedge ref_clk) disable iff (!rst_n)
		(stateQ == edmb_pkg::ST_HOLD && stateD == edmb_pkg::ST_IDLE && !stretch)
			|-> cycLenQ == 8'(edmb_pkg::CPU_PER_CYCLE) * oscPerCpu - 8'h01;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("bus cycle length wrong");

	property p_reg_indirect;
		@(posedge ref_clk) disable iff (!rst_n)
		take && !movxUsePtr |=> !usePtrQ && addrQ[15:8] == $past(highPortQ);
	endproperty
	a_reg_indirect: assert property (p_reg_indirect) else $error("high byte not port latch");

	property p_internal;
		@(posedge ref_clk) disable iff (!rst_n)
		take && reqInternal |-> ##2 movxDone && rdStrobe_n && wrStrobe_n;
	endproperty
	a_internal: assert property (p_internal) else $error("internal access misrouted");

	property p_free_ale;
		@(posedge ref_clk) disable iff (!rst_n)
		(stateQ == edmb_pkg::ST_IDLE && !movxReq && !latchDis && alePhase) |=> addrLatch;
	endproperty
	a_free_ale: assert property (p_free_ale) else $error("free latch strobe missing");

	property p_quiet_ale;
		@(posedge ref_clk) disable iff (!rst_n)
		(stateQ == edmb_pkg::ST_IDLE && !movxReq && latchDis) |=> !addrLatch;
	endproperty
	a_quiet_ale: assert property (p_quiet_ale) else $error("latch strobe not disabled");

	property p_zero_bit;
		@(posedge ref_clk) disable iff (!rst_n)
		sfrRdEn && sfrAddr == edmb_pkg::SFR_AUX_PTR |=> !sfrRdData[edmb_pkg::BIT_PTR_ZERO];
	endproperty
	a_zero_bit: assert property (p_zero_bit) else $error("pointer register bit 2 set");
endmodule : edmb_bus

/* File: dv/edmb_ext_mem.sv */
/*
 * far-side model: external data memory on the multiplexed bus.
 * assumes the pins come straight from edmb_bus and the bench resolves the port wire.
 */
module edmb_ext_mem (
	// clock
	input  wire logic        ref_clk,
	// bus pins
	input  wire logic [7:0]  busPin,
	input  wire logic [7:0]  highAddr,
	input  wire logic        addrLatch,
	input  wire logic        rdStrobe_n,
	input  wire logic        wrStrobe_n,
	// drive and observed address
	output logic      [7:0]  memOut,
	output logic      [15:0] latchAddr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [65536];
	logic [7:0] idleQ = 8'h5A;
	always @(posedge ref_clk) begin
		if (addrLatch) latchAddr <= {highAddr, busPin};
		if (!wrStrobe_n) mem[latchAddr] <= busPin;
		idleQ <= ~idleQ;
	end
	// released port shows a toggling pattern so stale data can never pass
	assign memOut = !rdStrobe_n ? mem[latchAddr] : idleQ;
endmodule : edmb_ext_mem

/* File: dv/tb_top.sv */
/*
 * self-checking bench for edmb_bus with an external memory model.
 * assumes the port wire is resolved here from the block's output enable.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        ref_clk, rst_n, doubleSpeedMode, sfrWrEn, sfrRdEn, ptrInc;
	logic        movxReq, movxWrite, movxUsePtr, movxDone, lowAddrDataOe;
	logic        addrLatch, rdStrobe_n, wrStrobe_n, alePrev = 1'h0;
	logic [7:0]  sfrAddr, sfrWrData, sfrRdData, movxRegAddr, movxWrData, movxRdData;
	logic [7:0]  lowAddrDataOut, highAddrPort, memOut, busPin;
	logic [15:0] latchAddr;
	int          n_mismatch = 0, n_checks = 0, aleCnt = 0, rdCnt = 0, wrCnt = 0;
	assign busPin = lowAddrDataOe ? lowAddrDataOut : memOut;
	edmb_bus DUT (.ref_clk(ref_clk), .rst_n(rst_n), .doubleSpeedMode(doubleSpeedMode),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .ptrInc(ptrInc), .movxReq(movxReq), .movxWrite(movxWrite),
		.movxUsePtr(movxUsePtr), .movxRegAddr(movxRegAddr), .movxWrData(movxWrData),
		.movxDone(movxDone), .movxRdData(movxRdData), .lowAddrDataIn(busPin),
		.lowAddrDataOut(lowAddrDataOut), .lowAddrDataOe(lowAddrDataOe),
		.highAddrPort(highAddrPort), .addrLatch(addrLatch), .rdStrobe_n(rdStrobe_n),
		.wrStrobe_n(wrStrobe_n));
	edmb_ext_mem u_mem (.ref_clk(ref_clk), .busPin(busPin), .highAddr(highAddrPort),
		.addrLatch(addrLatch), .rdStrobe_n(rdStrobe_n), .wrStrobe_n(wrStrobe_n),
		.memOut(memOut), .latchAddr(latchAddr));
	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// pulse and strobe counters; tests take differences, never reset them
	always @(posedge ref_clk) begin
		alePrev <= addrLatch;
		if (addrLatch && !alePrev) aleCnt++;
		if (!rdStrobe_n) rdCnt++;
		if (!wrStrobe_n) wrCnt++;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chkRange(input string what, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chkRange
	task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfrWrEn <= 1'h1;
		sfrAddr <= a;
		sfrWrData <= d;
		@(posedge ref_clk);
		sfrWrEn <= 1'h0;
	endtask : sfrWr
	task automatic sfrChk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfrRdEn <= 1'h1;
		sfrAddr <= a;
		@(posedge ref_clk);
		sfrRdEn <= 1'h0;
		#1 chk("sfr read", exp, sfrRdData);
	endtask : sfrChk
	task automatic movx(input logic wr, input logic ptr, input logic [7:0] ra,
		input logic [7:0] wd, output int n);
		@(posedge ref_clk);
		movxReq <= 1'h1;
		movxWrite <= wr;
		movxUsePtr <= ptr;
		movxRegAddr <= ra;
		movxWrData <= wd;
		@(posedge ref_clk);
		movxReq <= 1'h0;
		n = 0;
		#1;
		while (movxDone !== 1'h1 && n < 300) begin
			@(posedge ref_clk);
			#1 n++;
		end
	endtask : movx
	task automatic t_regs();
		sfrChk(8'h8E, 8'h0C);
		sfrChk(8'hA2, 8'h00);
		sfrChk(8'hA0, 8'hFF);
		sfrChk(8'h83, 8'h00);
		sfrChk(8'h8F, 8'h00);
		sfrWr(8'h8E, 8'hFF);
		sfrChk(8'h8E, 8'h2F);
		$display("test regs done");
	endtask : t_regs
	task automatic t_ptr();
		sfrWr(8'hA2, 8'h00);
		sfrWr(8'h83, 8'h12);
		sfrWr(8'h84, 8'h34);
		sfrWr(8'hA2, 8'h01);
		sfrWr(8'h83, 8'h56);
		sfrWr(8'h84, 8'h78);
		sfrChk(8'h83, 8'h56);
		sfrWr(8'hA2, 8'h00);
		sfrChk(8'h84, 8'h34);
		@(posedge ref_clk);
		ptrInc <= 1'h1;
		@(posedge ref_clk);
		ptrInc <= 1'h0;
		sfrChk(8'h84, 8'h35);
		sfrWr(8'hA2, 8'h0C);
		sfrChk(8'hA2, 8'h08);
		sfrWr(8'hA2, 8'h09);
		sfrChk(8'hA2, 8'h09);
		sfrWr(8'hA2, 8'h0A);
		sfrChk(8'hA2, 8'h08);
		sfrChk(8'h83, 8'h12);
		$display("test pointers done");
	endtask : t_ptr
	task automatic t_ext(input logic x2, input logic stretch);
		int n, k, w, c, r0, w0;
		k = x2 ? 1 : 2;
		w = (stretch ? 15 : 3) * k;
		c = (stretch ? 18 : 6) * k;
		@(posedge ref_clk);
		doubleSpeedMode <= x2;
		sfrWr(8'h8E, {2'h0, stretch, 5'h0E});
		sfrWr(8'h83, 8'h12);
		sfrWr(8'h84, {6'h0D, x2, stretch});
		w0 = wrCnt;
		movx(1'h1, 1'h1, 8'h00, 8'hC3, n);
		chkRange("write cycle", c + 1, c + 2, n);
		chkRange("write strobe", w, w, wrCnt - w0);
		chk("bus address", {8'h12, 6'h0D, x2, stretch}, latchAddr);
		r0 = rdCnt;
		movx(1'h0, 1'h1, 8'h00, 8'h00, n);
		chkRange("read cycle", c + 1, c + 2, n);
		chkRange("read strobe", w, w, rdCnt - r0);
		chk("read data", 8'hC3, movxRdData);
		$display("test external cycle done");
	endtask : t_ext
	task automatic t_indirect();
		int n;
		sfrWr(8'h8E, 8'h0E);
		sfrWr(8'hA0, 8'h55);
		movx(1'h1, 1'h0, 8'h66, 8'hA7, n);
		chk("indirect address", 16'h5566, latchAddr);
		chk("port latch", 8'h55, highAddrPort);
		movx(1'h0, 1'h0, 8'h66, 8'h00, n);
		chk("indirect data", 8'hA7, movxRdData);
		$display("test indirect done");
	endtask : t_indirect
	task automatic t_internal();
		int n, a0;
		sfrWr(8'h8E, 8'h01);
		sfrWr(8'h83, 8'h00);
		sfrWr(8'h84, 8'h10);
		a0 = aleCnt;
		movx(1'h1, 1'h1, 8'h00, 8'h3C, n);
		chkRange("internal write", 1, 1, n);
		chkRange("no latch strobe", 0, 0, aleCnt - a0);
		movx(1'h0, 1'h1, 8'h00, 8'h00, n);
		chk("internal data", 8'h3C, movxRdData);
		sfrWr(8'h83, 8'h01);
		sfrWr(8'h84, 8'h50);
		a0 = aleCnt;
		movx(1'h1, 1'h1, 8'h00, 8'h77, n);
		chkRange("beyond size", 7, 40, n);
		chk("beyond size address", 16'h0150, latchAddr);
		chkRange("one latch strobe", 1, 1, aleCnt - a0);
		sfrWr(8'h8E, 8'h0D);
		sfrWr(8'h83, 8'h03);
		sfrWr(8'h84, 8'hFF);
		movx(1'h1, 1'h1, 8'h00, 8'h5A, n);
		chkRange("top internal", 1, 1, n);
		$display("test internal done");
	endtask : t_internal
	task automatic t_ale(input logic x2);
		int a0;
		@(posedge ref_clk);
		doubleSpeedMode <= x2;
		sfrWr(8'h8E, 8'h0C);
		repeat (12) @(posedge ref_clk);
		#1 a0 = aleCnt;
		repeat (60) @(posedge ref_clk);
		#1 chkRange("free latch strobe", x2 ? 20 : 10, x2 ? 20 : 10, aleCnt - a0);
		sfrWr(8'h8E, 8'h0D);
		repeat (4) @(posedge ref_clk);
		#1 a0 = aleCnt;
		repeat (60) @(posedge ref_clk);
		#1 chkRange("quiet latch strobe", 0, 0, aleCnt - a0);
		$display("test latch strobe done");
	endtask : t_ale
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	// whole run is well under a thousand cycles; this leaves a wide margin
	initial begin
		#300000;
		n_mismatch++;
		$display("watchdog expired");
		results();
	end
	initial begin
		rst_n = 1'h0;
		doubleSpeedMode = 1'h0;
		{sfrWrEn, sfrRdEn, ptrInc, movxReq, movxWrite, movxUsePtr} = 6'h00;
		{sfrAddr, sfrWrData, movxRegAddr, movxWrData} = 32'h0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_regs();
		t_ptr();
		t_ext(1'h0, 1'h0);
		t_ext(1'h0, 1'h1);
		t_ext(1'h1, 1'h0);
		t_ext(1'h1, 1'h1);
		t_indirect();
		t_internal();
		t_ale(1'h0);
		t_ale(1'h1);
		results();
	end
endmodule : tb_top
